// file: core/rpp_top.sv
// Reflected power protection controller: fast trip, shutback, cutback, foldback.
// Assumes samples arrive on sys_clk_i with a valid strobe; the coupler trip is asynchronous.
`timescale 1ns/10ps
`include "rpp_regs.svh"
module rpp_top #(
    parameter int TICK_CYC = `RPP_TICK_NS / `RPP_CLK_NS,
    parameter logic [35:0] RATED = 36'h0_4000_0000,
    parameter logic signed [3:0] Z0 = 4'sh1,
    parameter logic [15:0] REC_STEP [8] = '{16'h0100, 16'h0200, 16'h0400, 16'h0800,
                                            16'h1000, 16'h2000, 16'h4000, 16'h8000}
) (
    input wire logic sys_clk_i,                      // 200 MHz clock.
    input wire logic reset_i,                        // Synchronous reset, high.
    input wire logic refl_fast_i,                    // Coupler mismatch comparator, async.
    input wire logic signed [15:0] v_smp_i,          // Digitized RF voltage.
    input wire logic signed [15:0] i_smp_i,          // Digitized RF current.
    input wire logic smp_valid_i,                    // Sample pair valid.
    input wire logic [15:0] setpoint_i,              // Power set point.
    input wire logic [15:0] alc_i,                   // Level control value.
    input wire logic rf_on_i,                        // Transmitter RF on.
    output logic [15:0] pwr_cmd_o,                   // Power drive command.
    output logic pdm_zero_o,                         // Force modulation to zero.
    output logic rf_drive_en_o,                      // RF drive enable.
    output logic bypass_close_o,                     // Close all module relays.
    output logic cutback_o,                          // Power cap below full.
    output logic peak_trip_o                         // Last sample over peak limit.
);
    import rpp_pkg::*;

    localparam logic [15:0] FLOOR = 16'((32'(`RPP_PWR_FULL) * 32'(`RPP_FLOOR_PCT)) / 32'(`RPP_PCT_DIV));
    localparam logic [17:0] TICK_LAST = 18'(TICK_CYC - 1);

    rpp_state_type s_r;
    rpp_state_type s_nxt;

    // =============================================================
    // Helpers
    function automatic logic [15:0] rpp_min(input logic [15:0] a, input logic [15:0] b);
        return (a < b) ? a : b;
    endfunction

    function automatic logic [15:0] rpp_max(input logic [15:0] a, input logic [15:0] b);
        return (a > b) ? a : b;
    endfunction

    // =============================================================
    // Reflected wave from the load: (V - Z0*I) squared, the
    // impedance mismatch term, so a matched load gives zero.
    logic signed [19:0] diff;
    logic [35:0] refl;
    logic peak_hit;
    logic tick;
    logic trig;
    logic new_ev;
    logic [31:0] acc_add;
    logic [15:0] tgt;
    logic [15:0] cut_base;
    logic [23:0] cut_prod;
    logic [15:0] step;
    logic [55:0] avg_lhs;
    logic [55:0] avg_rhs;

    always_comb begin
        diff = 20'(v_smp_i) - 20'(Z0) * 20'(i_smp_i);
        refl = 36'(diff * diff);
        peak_hit = smp_valid_i && (48'(refl) * 48'(`RPP_PCT_DIV) > 48'(RATED) * 48'(`RPP_PK_PCT));
    end

    // =============================================================
    // Next state. Every mechanism updates in the same pass, none
    // is selected over another, so all protections act at once.
    always_comb begin
        s_nxt = s_r;
        step = REC_STEP[s_r.rec_idx];
        tick = (s_r.tick_cnt == TICK_LAST);
        s_nxt.tick_cnt = tick ? 18'h0_0000 : s_r.tick_cnt + 18'h0_0001;

        // Three stage synchroniser; a change counts when the last two agree.
        s_nxt.sync = {s_r.sync[1:0], refl_fast_i};
        if (s_r.sync[2] == s_r.sync[1]) begin
            s_nxt.fast = s_r.sync[2];
        end

        trig = peak_hit || s_r.fast;
        new_ev = trig && (s_r.mode != RPP_HOLD);
        tgt = rpp_min(rpp_min(setpoint_i, alc_i), rpp_min(s_r.cap, s_r.fold));

        // Accumulator: decay per ms, a new shutback adds one unit.
        if (tick && s_r.acc != 32'h0000_0000) begin
            s_nxt.acc = s_r.acc - 32'h0000_0001;
        end
        acc_add = s_nxt.acc + `RPP_ACC_ONE;
        cut_base = s_r.cut_seen ? s_r.cap : rpp_min(setpoint_i, s_r.pwr);
        cut_prod = 24'(cut_base) * 24'(`RPP_CUT_PCT);
        if (new_ev) begin
            // Adding rather than overwriting lets close events reach the threshold.
            s_nxt.acc = (acc_add > `RPP_ACC_MAX) ? `RPP_ACC_MAX : acc_add;
            if (s_nxt.acc > `RPP_ACC_CUT) begin
                s_nxt.cap = rpp_max(FLOOR, 16'(cut_prod / 24'(`RPP_PCT_DIV)));
                s_nxt.cut_seen = 1'b1;
                s_nxt.rec_tmr = 16'h0000;
                s_nxt.rec_idx = 3'h0;
            end
        end

        // Cap recovery only once the accumulator is empty.
        if (!new_ev && s_r.acc == 32'h0000_0000 && s_r.cap != `RPP_PWR_FULL && tick) begin
            s_nxt.rec_tmr = s_r.rec_tmr + 16'h0001;
            if (s_r.rec_tmr == `RPP_REC_MS - 16'h0001) begin
                s_nxt.rec_tmr = 16'h0000;
                s_nxt.cap = (`RPP_PWR_FULL - s_r.cap < step) ? `RPP_PWR_FULL : s_r.cap + step;
                if (s_r.rec_idx != 3'h7) begin
                    s_nxt.rec_idx = s_r.rec_idx + 3'h1;
                end
            end
        end
        if (s_nxt.cap == `RPP_PWR_FULL) begin
            s_nxt.cut_seen = 1'b0;
        end

        // Foldback on the long average of reflected power.
        if (smp_valid_i) begin
            s_nxt.last = refl;
        end
        avg_lhs = 56'(s_r.avg) * 56'(`RPP_PCT_DIV);
        avg_rhs = (56'(RATED) * 56'(`RPP_AVG_PCT)) << `RPP_AVG_SH;
        if (tick) begin
            s_nxt.avg = s_r.avg - (s_r.avg >> `RPP_AVG_SH) + 48'(s_r.last);
            if (avg_lhs > avg_rhs) begin
                s_nxt.fold = (s_r.fold < `RPP_FOLD_STEP) ? 16'h0000 : s_r.fold - `RPP_FOLD_STEP;
            end else begin
                s_nxt.fold = (`RPP_PWR_FULL - s_r.fold < `RPP_FOLD_STEP) ? `RPP_PWR_FULL
                                                                           : s_r.fold + `RPP_FOLD_STEP;
            end
        end

        // Shutback sequencing; tmr counts ms since the last trigger.
        unique case (s_r.mode)
            RPP_NORM: begin
                s_nxt.pwr = tgt;
            end
            RPP_HOLD: begin
                s_nxt.pwr = 16'h0000;
                if (tick) begin
                    s_nxt.tmr = s_r.tmr + 16'h0001;
                    if (s_r.tmr == `RPP_HOLD_MS - 16'h0001) begin
                        s_nxt.mode = RPP_RAMP;
                    end
                end
            end
            RPP_RAMP: begin
                if (s_r.pwr >= tgt) begin
                    s_nxt.pwr = tgt;
                end else if (tick) begin
                    // Exponential approach; a minimum step avoids stalling short of target.
                    s_nxt.pwr = s_r.pwr + rpp_max(16'h0001, (tgt - s_r.pwr) >> `RPP_RAMP_SH);
                end
                if (tick) begin
                    s_nxt.tmr = s_r.tmr + 16'h0001;
                    if (s_r.tmr == `RPP_FULL_MS - 16'h0001) begin
                        s_nxt.mode = RPP_NORM;
                    end
                end
            end
        endcase
        if (trig) begin
            s_nxt.mode = RPP_HOLD;
            s_nxt.tmr = 16'h0000;
            s_nxt.pwr = 16'h0000;
        end

        // Output flags registered from the next state.
        s_nxt.pdm_zero = s_nxt.fast || (s_nxt.mode == RPP_HOLD);
        s_nxt.drv_en = rf_on_i && !s_nxt.fast;
        s_nxt.relay = !rf_on_i || s_nxt.fast;
        s_nxt.cutback = (s_nxt.cap != `RPP_PWR_FULL);
        s_nxt.peak = peak_hit;
    end

    // =============================================================
    // State register.
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            s_r <= '{sync: 3'h0, fast: 1'b0, tick_cnt: 18'h0_0000, tmr: 16'h0000, mode: RPP_NORM,
                     acc: 32'h0000_0000, cap: `RPP_PWR_FULL, cut_seen: 1'b0, rec_tmr: 16'h0000,
                     rec_idx: 3'h0, last: 36'h0_0000_0000, avg: 48'h0000_0000_0000,
                     fold: `RPP_PWR_FULL, pwr: 16'h0000, pdm_zero: 1'b1, drv_en: 1'b0,
                     relay: 1'b1, cutback: 1'b0, peak: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign pwr_cmd_o = s_r.pwr;
    assign pdm_zero_o = s_r.pdm_zero;
    assign rf_drive_en_o = s_r.drv_en;
    assign bypass_close_o = s_r.relay;
    assign cutback_o = s_r.cutback;
    assign peak_trip_o = s_r.peak;

    // =============================================================
    // Checks, all on the one clock.
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);

    AST_FAST_TRIP: assert property (refl_fast_i [*4] |=> pdm_zero_o && !rf_drive_en_o)
        else $error("fast trip did not stop drive");
    AST_PEAK_ZERO: assert property (peak_hit |=> pwr_cmd_o == 16'h0000 && s_r.mode == RPP_HOLD)
        else $error("peak did not force zero power");
    AST_HOLD_ZERO: assert property (s_r.mode == RPP_HOLD |-> pwr_cmd_o == 16'h0000 && pdm_zero_o)
        else $error("power not zero during hold");
    AST_ACC_SET: assert property (new_ev |=> s_r.acc >= `RPP_ACC_ONE)
        else $error("accumulator not loaded on shutback");
    AST_ACC_DECAY: assert property (tick && !new_ev && s_r.acc != 32'h0000_0000
                                    |=> s_r.acc == $past(s_r.acc) - 32'h0000_0001)
        else $error("accumulator decay wrong");
    AST_CAP_FLOOR: assert property (s_r.cap >= FLOOR)
        else $error("cap below floor");
    AST_REC_WAIT: assert property (s_r.acc != 32'h0000_0000 |=> s_r.cap <= $past(s_r.cap))
        else $error("cap rose while accumulator nonzero");
    AST_RELAY: assert property (!rf_on_i |=> bypass_close_o)
        else $error("relays open at shutdown");
    AST_NORM_ALC: assert property (s_r.mode == RPP_NORM && !trig |=> pwr_cmd_o == $past(tgt))
        else $error("normal mode not following target");

    COV_SHUTBACK: cover property (new_ev ##1 s_r.mode == RPP_HOLD);
    COV_CUTBACK: cover property (!cutback_o ##1 cutback_o);
    COV_RECOVER: cover property (cutback_o ##1 !cutback_o);
endmodule // rpp_top

// file: include/rpp_pkg.sv
// Types shared by the reflected power protection block.
// Assumes rpp_regs.svh is on the include path.
`include "rpp_regs.svh"
package rpp_pkg;

    // Power recovery phases after a shutback.
    typedef enum logic [1:0] {RPP_NORM, RPP_HOLD, RPP_RAMP} rpp_mode_type;

    // Whole state of the block, registered in one place.
    typedef struct packed {
        logic [2:0] sync;
        logic fast;
        logic [17:0] tick_cnt;
        logic [15:0] tmr;
        rpp_mode_type mode;
        logic [31:0] acc;
        logic [15:0] cap;
        logic cut_seen;
        logic [15:0] rec_tmr;
        logic [2:0] rec_idx;
        logic [35:0] last;
        logic [47:0] avg;
        logic [15:0] fold;
        logic [15:0] pwr;
        logic pdm_zero;
        logic drv_en;
        logic relay;
        logic cutback;
        logic peak;
    } rpp_state_type;

endpackage

// file: include/rpp_regs.svh
// Timing, threshold and scaling constants of the reflected power protection block.
// Assumes a single 200 MHz clock and power values scaled so that 16'hFFFF is full carrier.
//
// Overview of operation
// - Coupler fast trip zeroes modulation, kills drive.
// - Peak reflected above sixteen percent triggers shutback.
// - Shutback drops power command instantly to zero.
// - Power held at zero for hold interval.
// - Exponential ramp toward lower of setpoint, ALC.
// - Full power under ALC thirty seconds after shutback.
// - Shutback adds one unit to accumulator.
// - Accumulator decays one sixtieth each second.
// - Accumulator above threshold declares a cutback.
// - First cutback caps power at eighty-five percent.
// - Further cutbacks scale the cap again.
// - Cap never falls below two percent.
// - Cap recovery waits for accumulator at zero.
// - Four second average above four percent folds back.
// - All protection paths run concurrently.
// - Load impedance mismatch from current, voltage samples.
// - Shutdown closes every module bypass relay.
`ifndef RPP_REGS_SVH
`define RPP_REGS_SVH

// =============================================================
// Time base
`define RPP_CLK_NS 32'h0000_0005
`define RPP_TICK_NS 32'h000F_4240
`define RPP_HOLD_MS 16'h012C
`define RPP_FULL_MS 16'h7530
`define RPP_REC_MS 16'h03E8

// =============================================================
// Accumulator, one unit is 60000 ticks of 1 ms
`define RPP_ACC_ONE 32'h0000_EA60
`define RPP_ACC_CUT 32'h0002_49F0
`define RPP_ACC_MAX 32'h0003_A980

// =============================================================
// Levels and percentages
`define RPP_PWR_FULL 16'hFFFF
`define RPP_PK_PCT 8'h10
`define RPP_AVG_PCT 8'h04
`define RPP_CUT_PCT 8'h55
`define RPP_FLOOR_PCT 8'h02
`define RPP_PCT_DIV 8'h64
`define RPP_AVG_SH 4'hC
`define RPP_RAMP_SH 4'h6
`define RPP_FOLD_STEP 16'h0010

`endif

// file: testbench/rpp_probe_model.sv
// Behavioural model of the RF probes and converters feeding the protection block.
// Assumes the bench sets the reflected amplitude and the coupler trip request.
`timescale 1ns/10ps
module rpp_probe_model (
    input wire logic sys_clk_i,              // Bench clock.
    input wire logic [15:0] refl_amp_i,      // Reflected voltage amplitude.
    input wire logic trip_i,                 // Coupler over-limit request.
    output logic signed [15:0] v_smp_o,      // Digitized voltage.
    output logic signed [15:0] i_smp_o,      // Digitized current.
    output logic smp_valid_o,                // Sample pair valid.
    output logic refl_fast_o                 // Coupler comparator.
);
    logic [11:0] cnt_r;
    logic slot;

    // =============================================================
    // Sample pairs
    // Current sweeps so the impedance path sees real pairs; voltage carries the reflected excess.
    // Every eighth slot is idle and shows inverted junk, so a stale pair never passes for a fresh one.
    assign slot = (cnt_r[2:0] != 3'h7);
    initial begin
        cnt_r = 12'h000;
        v_smp_o = 16'h0000;
        i_smp_o = 16'h0000;
        smp_valid_o = 1'b0;
        refl_fast_o = 1'b0;
    end
    always @(posedge sys_clk_i) begin
        cnt_r <= cnt_r + 12'h001;
        smp_valid_o <= slot;
        i_smp_o <= slot ? $signed({4'h0, cnt_r}) : ~i_smp_o;
        v_smp_o <= slot ? $signed({4'h0, cnt_r} + refl_amp_i) : ~v_smp_o;
        refl_fast_o <= trip_i;
    end
endmodule // rpp_probe_model

// file: testbench/rpp_top_test.sv
// Self-checking bench of the reflected power protection block with a probe model.
// Assumes the tick is shortened to two clocks, so every millisecond count is two cycles.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end
module rpp_top_test;
    logic sys_clk_i, reset_i, rf_on_i, trip_r, smp_valid_i, refl_fast_i;
    logic [15:0] setpoint_i, alc_i, amp_r, pwr_cmd_o;
    logic signed [15:0] v_smp_i, i_smp_i;
    logic pdm_zero_o, rf_drive_en_o, bypass_close_o, cutback_o, peak_trip_o;
    int bad_count = 0;
    int checks_done = 0;
    int cyc = 0;

    rpp_probe_model PROBE (.sys_clk_i(sys_clk_i), .refl_amp_i(amp_r), .trip_i(trip_r), .v_smp_o(v_smp_i),
        .i_smp_o(i_smp_i), .smp_valid_o(smp_valid_i), .refl_fast_o(refl_fast_i));
    rpp_top #(.TICK_CYC(2)) DUT (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .refl_fast_i(refl_fast_i),
        .v_smp_i(v_smp_i), .i_smp_i(i_smp_i), .smp_valid_i(smp_valid_i), .setpoint_i(setpoint_i),
        .alc_i(alc_i), .rf_on_i(rf_on_i), .pwr_cmd_o(pwr_cmd_o), .pdm_zero_o(pdm_zero_o),
        .rf_drive_en_o(rf_drive_en_o), .bypass_close_o(bypass_close_o), .cutback_o(cutback_o),
        .peak_trip_o(peak_trip_o));

    // =============================================================
    // Clock, watchdog and verdict
    initial begin
        sys_clk_i = 1'b0;
        forever #2.5 sys_clk_i = ~sys_clk_i;
    end
    // The ceiling sits well above the roughly 11200 cycles the scenarios need.
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 40000) begin
            bad_count++;
            conclude();
        end
    end
    task automatic conclude();
        if (bad_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // =============================================================
    // Shared steps
    // Reads happen at the edge, before that edge's updates land, so they see settled values.
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask
    task automatic start(input logic [15:0] sp, input logic [15:0] al);
        reset_i <= 1'b1;
        setpoint_i <= sp;
        alc_i <= al;
        amp_r <= 16'h0000;
        trip_r <= 1'b0;
        rf_on_i <= 1'b1;
        step(6);
        `CHK("pwr_in_reset", 16'h0000, pwr_cmd_o);
        `CHK("relay_in_reset", 1'b1, bypass_close_o);
        reset_i <= 1'b0;
        step(10);
    endtask
    // A reflected excess of 0x7000 is far over the peak limit; it is removed once the trip is seen.
    task automatic shot();
        int k;
        amp_r <= 16'h7000;
        for (k = 0; k < 20 && peak_trip_o !== 1'b1; k++) step(1);
        `CHK("peak_trip", 1'b1, peak_trip_o);
        `CHK("pwr_at_trip", 16'h0000, pwr_cmd_o);
        `CHK("pdm_at_trip", 1'b1, pdm_zero_o);
        amp_r <= 16'h0000;
    endtask

    // =============================================================
    // Scenarios
    task automatic t_normal();
        start(16'h8000, 16'h6000);
        `CHK("pwr_follow", 16'h6000, pwr_cmd_o);
        `CHK("drive_on", 1'b1, rf_drive_en_o);
        `CHK("relay_open", 1'b0, bypass_close_o);
        alc_i <= 16'h9000;
        step(4);
        `CHK("pwr_alc", 16'h8000, pwr_cmd_o);
        // The backup push-button RF off command arrives as a plain level.
        rf_on_i <= 1'b0;
        step(4);
        `CHK("relay_rf_off", 1'b1, bypass_close_o);
        rf_on_i <= 1'b1;
    endtask
    task automatic t_shutback();
        start(16'h8000, 16'h6000);
        amp_r <= 16'h3000;
        step(20);
        `CHK("no_trip_below", 1'b0, peak_trip_o);
        shot();
        step(585);
        `CHK("pwr_hold", 16'h0000, pwr_cmd_o);
        `CHK("pdm_hold", 1'b1, pdm_zero_o);
        step(100);
        `CHK("ramp_mid", 1'b1, pwr_cmd_o > 16'h0000 && pwr_cmd_o < 16'h6000);
        step(1200);
        `CHK("ramp_end", 16'h6000, pwr_cmd_o);
        `CHK("one_shot_no_cut", 1'b0, cutback_o);
    endtask
    // A low set point puts the first 85 % cap below the floor of 0x051E at once.
    task automatic t_cutback();
        int n;
        start(16'h0600, 16'hFFFF);
        for (n = 0; n < 4; n++) begin
            shot();
            step(700);
            `CHK("cutback_flag", (n >= 2) ? 1'b1 : 1'b0, cutback_o);
        end
        step(1400);
        `CHK("cap_floor", 16'h051E, pwr_cmd_o);
        `CHK("cap_held", 1'b1, cutback_o);
    endtask
    task automatic t_fast();
        start(16'hFFFF, 16'hFFFF);
        trip_r <= 1'b1;
        step(8);
        `CHK("fast_pdm", 1'b1, pdm_zero_o);
        `CHK("fast_drive", 1'b0, rf_drive_en_o);
        `CHK("fast_relay", 1'b1, bypass_close_o);
        step(1);
        `CHK("fast_pwr", 16'h0000, pwr_cmd_o);
        trip_r <= 1'b0;
        step(8);
        `CHK("fast_release", 1'b0, bypass_close_o);
    endtask
    // A steady excess of 0x3000 is over the average limit but under the peak limit.
    task automatic t_fold();
        start(16'hFFFF, 16'hFFFF);
        amp_r <= 16'h3000;
        step(5000);
        `CHK("fold_no_peak", 1'b0, peak_trip_o);
        `CHK("fold_cut", 1'b1, pwr_cmd_o < 16'hFFFF && pwr_cmd_o > 16'h0000);
    endtask

    // =============================================================
    // Main sequence
    initial begin
        reset_i = 1'b1;
        rf_on_i = 1'b0;
        trip_r = 1'b0;
        amp_r = 16'h0000;
        setpoint_i = 16'h0000;
        alc_i = 16'h0000;
        t_normal();
        t_shutback();
        t_cutback();
        t_fast();
        t_fold();
        conclude();
    end
endmodule // rpp_top_test
